// File: rtl/pie_consts.svh
// register offsets, field positions and reset values of the enable bank
`ifndef PIE_CONSTS_SVH
`define PIE_CONSTS_SVH
`define PIE_ADDR_LOGIC_TIMER_GATE 12'h71b
`define PIE_ADDR_CAPTURE_COMPARE 12'h71c
`define PIE_ADDR_INT_CONTROL 12'h720
`define PIE_RST_LOGIC_TIMER_GATE 8'h00
`define PIE_RST_CAPTURE_COMPARE 8'h00
`define PIE_RST_INT_CONTROL 8'h00
`define PIE_MASK_LOGIC_TIMER_GATE 8'hf7
`define PIE_MASK_CAPTURE_COMPARE 8'h0f
`define PIE_MASK_INT_CONTROL 8'h40
`define PIE_BIT_GLOBAL_PERIPH 6
`define PIE_CELL_HI 7
`define PIE_CELL_LO 4
`define PIE_TGATE_HI 2
`define PIE_TGATE_LO 0
`define PIE_CC_HI 3
`define PIE_CC_LO 0
`endif

// File: rtl/pie_pkg.sv
// types of the peripheral interrupt enable bank
`default_nettype none
package pie_pkg;
    typedef struct packed {
        logic [3:0] logic_cell;  // cells 4..1
        logic [2:0] timer_gate;  // timers 5,3,1
        logic [3:0] capcomp;     // units 4..1
    } pie_irq_t;
endpackage : pie_pkg
`default_nettype wire

// File: rtl/pie_enable_bank.sv
// peripheral interrupt enable bank with gating toward the core
// ==========================================================
// Overview of operation
// - first register: logic cells 4..1, bit3 absent
// - first register bits 2..0: timer gates 5,3,1
// - second register: capture/compare 4..1 in bits 3..0
// - enable 1 passes, 0 blocks; reset clears
// - global peripheral enable gates every request
`timescale 1ns/1ps
`default_nettype none
`include "pie_consts.svh"
module pie_enable_bank #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk,                // 50 MHz clock
    input wire logic rst_b,                  // async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr,  // register address
    input wire logic [7:0] reg_wdata,        // write data
    input wire logic reg_wr,                 // write strobe
    input wire logic reg_rd,                 // read strobe
    output logic [7:0] reg_rdata,            // read data, cycle after rd
    input wire pie_pkg::pie_irq_t irq_req,   // peripheral flags, same clock
    output pie_pkg::pie_irq_t irq_out        // gated requests to core
);
    // the decoder compares against 12-bit offsets
    if (ADDR_W < 12) begin : g_addr_w_chk
        $error("ADDR_W must be at least 12");
    end

    // ==========================================================
    // reset release
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ==========================================================
    // registers
    logic [7:0] ltg_q, ltg_d, cc_q, cc_d, ictl_q, ictl_d, rdata_d;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    always_comb begin
        ltg_d = ltg_q;
        cc_d = cc_q;
        ictl_d = ictl_q;
        rdata_d = 8'h00;
        if (reg_wr) begin
            if (hit(reg_addr, `PIE_ADDR_LOGIC_TIMER_GATE))
                ltg_d = reg_wdata & `PIE_MASK_LOGIC_TIMER_GATE;
            if (hit(reg_addr, `PIE_ADDR_CAPTURE_COMPARE))
                cc_d = reg_wdata & `PIE_MASK_CAPTURE_COMPARE;
            if (hit(reg_addr, `PIE_ADDR_INT_CONTROL))
                ictl_d = reg_wdata & `PIE_MASK_INT_CONTROL;
        end
        // unmapped addresses read zero
        if (reg_rd) begin
            if (hit(reg_addr, `PIE_ADDR_LOGIC_TIMER_GATE))
                rdata_d = ltg_q;
            else if (hit(reg_addr, `PIE_ADDR_CAPTURE_COMPARE))
                rdata_d = cc_q;
            else if (hit(reg_addr, `PIE_ADDR_INT_CONTROL))
                rdata_d = ictl_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ltg_q <= `PIE_RST_LOGIC_TIMER_GATE;
            cc_q <= `PIE_RST_CAPTURE_COMPARE;
            ictl_q <= `PIE_RST_INT_CONTROL;
            reg_rdata <= 8'h00;
        end else if (!rst_n_q) begin
            ltg_q <= `PIE_RST_LOGIC_TIMER_GATE;
            cc_q <= `PIE_RST_CAPTURE_COMPARE;
            ictl_q <= `PIE_RST_INT_CONTROL;
            reg_rdata <= 8'h00;
        end else begin
            ltg_q <= ltg_d;
            cc_q <= cc_d;
            ictl_q <= ictl_d;
            reg_rdata <= rdata_d;
        end
    end

    // ==========================================================
    // gating; registered so the core sees a glitch-free level
    logic global_en;
    pie_pkg::pie_irq_t irq_d;
    assign global_en = ictl_q[`PIE_BIT_GLOBAL_PERIPH];
    always_comb begin
        irq_d.logic_cell = irq_req.logic_cell
                           & ltg_q[`PIE_CELL_HI:`PIE_CELL_LO]
                           & {4{global_en}};
        irq_d.timer_gate = irq_req.timer_gate
                           & ltg_q[`PIE_TGATE_HI:`PIE_TGATE_LO]
                           & {3{global_en}};
        irq_d.capcomp = irq_req.capcomp
                        & cc_q[`PIE_CC_HI:`PIE_CC_LO]
                        & {4{global_en}};
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            irq_out <= '0;
        else if (!rst_n_q)
            irq_out <= '0;
        else
            irq_out <= irq_d;
    end

    // ==========================================================
    // checks
    // the synchroniser holds no value before its first clock edge, so
    // checks wait for the pin and both stages to leave reset
    logic chk_en;
    assign chk_en = rst_b && rst_n_q;

    global_gate_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        !$past(global_en) |-> irq_out == '0)
        else $error("request passed with global enable off");

    cell_pass_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        irq_out.logic_cell == $past(irq_req.logic_cell
            & ltg_q[`PIE_CELL_HI:`PIE_CELL_LO] & {4{global_en}}))
        else $error("logic cell gating wrong");

    timer_pass_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        irq_out.timer_gate == $past(irq_req.timer_gate
            & ltg_q[`PIE_TGATE_HI:`PIE_TGATE_LO] & {3{global_en}}))
        else $error("timer gate gating wrong");

    capcomp_pass_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        irq_out.capcomp == $past(irq_req.capcomp
            & cc_q[`PIE_CC_HI:`PIE_CC_LO] & {4{global_en}}))
        else $error("capture compare gating wrong");

    cc_block_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        $past(cc_q[`PIE_CC_HI:`PIE_CC_LO]) == 4'h0 |->
        irq_out.capcomp == 4'h0)
        else $error("disabled capture compare passed");

    write_store_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        reg_wr && hit(reg_addr, `PIE_ADDR_LOGIC_TIMER_GATE) |=>
        ltg_q == ($past(reg_wdata) & `PIE_MASK_LOGIC_TIMER_GATE))
        else $error("enable write not stored");

    cc_store_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        reg_wr && hit(reg_addr, `PIE_ADDR_CAPTURE_COMPARE) |=>
        cc_q == ($past(reg_wdata) & `PIE_MASK_CAPTURE_COMPARE))
        else $error("capture compare write not stored");

    ictl_store_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        reg_wr && hit(reg_addr, `PIE_ADDR_INT_CONTROL) |=>
        ictl_q == ($past(reg_wdata) & `PIE_MASK_INT_CONTROL))
        else $error("control write not stored");

    hold_enables_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        !reg_wr |=> $stable(ltg_q) && $stable(cc_q))
        else $error("enables changed without a write");

    hold_ctrl_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        !reg_wr |=> $stable(ictl_q))
        else $error("control changed without a write");

    unimpl_zero_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        ltg_q[3] == 1'b0 && cc_q[7:4] == 4'h0)
        else $error("unimplemented bit set");

    ltg_read_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        reg_rd && hit(reg_addr, `PIE_ADDR_LOGIC_TIMER_GATE) |=>
        reg_rdata == $past(ltg_q))
        else $error("logic timer gate readback wrong");

    read_back_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        reg_rd && hit(reg_addr, `PIE_ADDR_CAPTURE_COMPARE) |=>
        reg_rdata == $past(cc_q))
        else $error("capture compare readback wrong");

    ictl_read_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        reg_rd && hit(reg_addr, `PIE_ADDR_INT_CONTROL) |=>
        reg_rdata == $past(ictl_q))
        else $error("control readback wrong");

    unmapped_read_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        reg_rd && !hit(reg_addr, `PIE_ADDR_LOGIC_TIMER_GATE)
        && !hit(reg_addr, `PIE_ADDR_CAPTURE_COMPARE)
        && !hit(reg_addr, `PIE_ADDR_INT_CONTROL) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    rdata_idle_a: assert property (
        @(posedge sys_clk) disable iff (!chk_en)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data stands without a read");

    reset_clear_a: assert property (
        @(posedge sys_clk)
        !rst_n_q |-> ##1 (ltg_q == `PIE_RST_LOGIC_TIMER_GATE
                          && cc_q == `PIE_RST_CAPTURE_COMPARE))
        else $error("enables not cleared by reset");

    ctrl_reset_a: assert property (
        @(posedge sys_clk)
        !rst_n_q |-> ##1 (ictl_q == `PIE_RST_INT_CONTROL && irq_out == '0))
        else $error("control or requests not cleared by reset");
endmodule : pie_enable_bank
`default_nettype wire

// File: bench/pie_flag_src.sv
// peripheral flag source model driving request levels
`timescale 1ns/1ps
`default_nettype none
module pie_flag_src (
    input wire logic clk,           // system clock
    output pie_pkg::pie_irq_t flags // request levels toward the bank
);
    integer seed = 84;
    // levels move every cycle so each enable bit sees both values
    always @(posedge clk) flags <= pie_pkg::pie_irq_t'(11'($random(seed)));
endmodule : pie_flag_src
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the peripheral interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
`include "pie_consts.svh"
module tb_top;
    logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic [11:0] reg_addr = '0, a;
    logic [7:0] reg_wdata = '0, reg_rdata, m_lt = '0, m_cc = '0, m_ic = '0;
    logic [10:0] exp_irq;
    pie_pkg::pie_irq_t irq_req, irq_out;
    int bad_count = 0, total_checks = 0, cyc = 0, seed = 84;
    // the last entry is unmapped: writes vanish, reads give zero
    logic [11:0] addrs [4] = '{`PIE_ADDR_LOGIC_TIMER_GATE,
        `PIE_ADDR_CAPTURE_COMPARE, `PIE_ADDR_INT_CONTROL, 12'h7ff};
    pie_enable_bank u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req),
        .irq_out(irq_out));
    pie_flag_src u_src (.clk(sys_clk), .flags(irq_req));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic final_report();
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [10:0] e, s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask : chk
    function automatic logic [7:0] exp_rd(input logic [11:0] ad);
        case (ad)
            `PIE_ADDR_LOGIC_TIMER_GATE: return m_lt;
            `PIE_ADDR_CAPTURE_COMPARE: return m_cc;
            `PIE_ADDR_INT_CONTROL: return m_ic;
            default: return 8'h00;
        endcase
    endfunction : exp_rd
    // bus tasks start right after a rising edge
    task automatic wr(input logic [11:0] ad, input logic [7:0] d);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        case (ad)
            `PIE_ADDR_LOGIC_TIMER_GATE:
                m_lt <= d & `PIE_MASK_LOGIC_TIMER_GATE;
            `PIE_ADDR_CAPTURE_COMPARE:
                m_cc <= d & `PIE_MASK_CAPTURE_COMPARE;
            `PIE_ADDR_INT_CONTROL:
                m_ic <= d & `PIE_MASK_INT_CONTROL;
            default: ;
        endcase
    endtask : wr
    task automatic rd(input logic [11:0] ad);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk("reg_rdata", 11'(exp_rd(ad)), 11'(reg_rdata));
        @(posedge sys_clk);
    endtask : rd
    // one-cycle gating model, also the run limit
    always @(posedge sys_clk) begin
        exp_irq <= irq_req & {m_lt[7:4], m_lt[2:0], m_cc[3:0]}
            & {11{m_ic[6]}};
        cyc <= cyc + 1;
        if (cyc > 2000) begin
            bad_count++;
            final_report();
        end
    end
    // an asserted pin clears the output at once, ahead of the model's edge
    always @(negedge sys_clk) begin
        if (cyc > 0)
            chk("irq_out", rst_b ? exp_irq : 11'h000, irq_out);
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (addrs[i]) rd(addrs[i]);
        wr(`PIE_ADDR_LOGIC_TIMER_GATE, 8'hff);
        @(posedge sys_clk);
        wr(`PIE_ADDR_CAPTURE_COMPARE, 8'hff);
        repeat (8) @(posedge sys_clk);
        wr(`PIE_ADDR_INT_CONTROL, 8'hff);
        repeat (8) @(posedge sys_clk);
        for (int i = 0; i < 60; i++) begin
            a = addrs[2'($random(seed))];
            wr(a, 8'($random(seed)));
            rd(a);
        end
        // mid-run reset must clear every enable and the global gate
        rst_b <= 1'b0;
        m_lt <= `PIE_RST_LOGIC_TIMER_GATE;
        m_cc <= `PIE_RST_CAPTURE_COMPARE;
        m_ic <= `PIE_RST_INT_CONTROL;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        foreach (addrs[i]) rd(addrs[i]);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
